// *** core/pmc_pkg.sv ***
// Package with register map, field layout and widths of the monitoring counter bank
package pmc_pkg;
	localparam int ADDR_W = 9;
	localparam logic [8:0] OFS_FRM_LO = 9'h050;
	localparam logic [8:0] OFS_FRM_HI = 9'h051;
	localparam logic [8:0] OFS_CRC_LO = 9'h052;
	localparam logic [8:0] OFS_CRC_HI = 9'h053;
	localparam logic [8:0] OFS_LCV_LO = 9'h054;
	localparam logic [8:0] OFS_LCV_HI = 9'h055;
	localparam logic [8:0] OFS_FAR_LO = 9'h056;
	localparam logic [8:0] OFS_FAR_HI = 9'h057;
	localparam logic [8:0] OFS_PAT_LO = 9'h058;
	localparam logic [8:0] OFS_PAT_HI = 9'h059;
	localparam logic [8:0] OFS_ALM    = 9'h05a;
	localparam logic [8:0] OFS_SA4    = 9'h05b;
	localparam logic [8:0] OFS_SA5    = 9'h05c;
	localparam int FRM_W = 12;
	localparam int CRC_W = 10;
	localparam int LCV_W = 16;
	localparam int FAR_W = 10;
	localparam int PAT_W = 12;
	localparam int LOA_W = 4;
	localparam int COA_W = 2;
	localparam int SEF_W = 2;
	localparam int SA_W  = 8;
	// Overflow enable vector positions
	localparam int OV_FRM = 0;
	localparam int OV_CRC = 1;
	localparam int OV_LCV = 2;
	localparam int OV_FAR = 3;
	localparam int OV_PAT = 4;
	localparam int OV_LOA = 5;
	localparam int OV_COA = 6;
	localparam int OV_SEF = 7;
	localparam logic [7:0] RST_BYTE = 8'h00;
endpackage

// *** core/pmc_counters.sv ***
// Receive performance monitoring counter bank and Sa4/Sa5 receive buffers
// Contract
// - Overflow enable set: counter wraps to zero past its maximum.
// - Overflow enable clear: counter saturates at all ones until cleared.
// - 12-bit framing error count; high byte read clears it when unlatched.
// - 10-bit CRC error count; high byte read clears it when unlatched.
// - 16-bit line violation count, excess zeros optional; high read clears.
// - 10-bit far-end block error count; any read clears when unlatched.
// - Pattern low read snapshots internal count, then zeroes internal counter.
// - Pattern high byte returns bits captured at last low read.
// - Pattern error counter counts only while test start is set.
// - One alarm register read clears all three alarm count fields.
// - Alarm bits 7:4 count loss of frame alignment occurrences.
// - Alarm bits 3:2 count reframe pulses to new bit position.
// - Alarm bits 1:0 count severely errored frame detections.
// - Sa buffers double-buffered, reloaded together at multiframe interrupt.
// - Buffer bit n holds Sa bit of odd frame 2n+1.
// - Visible Sa buffers stay stable between multiframe interrupts.
// - Loss count advances on rising edge of alignment loss status.
`timescale 1ns/100ps
`default_nettype none
module pmc_counters (
	// Clock and reset
	input  wire logic                      core_clk,
	input  wire logic                      resetn,
	// Processor register port
	input  wire logic [pmc_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic                      reg_rd,
	output logic      [7:0]                reg_rdata,
	// Configuration
	input  wire logic [7:0]                counter_overflow_irq_enable,
	input  wire logic                      one_second_latch_active,
	input  wire logic                      one_second_tick,
	input  wire logic                      excess_zero_in_violation_count,
	input  wire logic                      pattern_test_start,
	input  wire logic                      e1_mode,
	// Error events from the receive domain, counted once per cycle high; frame_align_lost is a status level counted on its rising edge
	input  wire logic                      framing_bit_error,
	input  wire logic                      crc_error,
	input  wire logic                      bipolar_violation,
	input  wire logic                      excess_zero_event,
	input  wire logic                      far_block_error,
	input  wire logic                      pattern_bit_error,
	input  wire logic                      frame_align_lost,
	input  wire logic                      alignment_change,
	input  wire logic                      severe_frame_error,
	// Sa bit capture
	input  wire logic                      sa_bit_valid,
	input  wire logic [2:0]                sa_odd_frame_index,
	input  wire logic                      sa4_bit,
	input  wire logic                      sa5_bit,
	input  wire logic                      rx_multiframe_irq,
	// Overflow pulses toward the interrupt logic
	output logic      [7:0]                counter_overflow
);
	import pmc_pkg::*;

	// Increment with wrap or saturation; cleared value still takes the event
	function automatic logic [15:0] bump(input logic [15:0] cur, input logic [15:0] maxv,
		input logic ev, input logic clr, input logic wrap);
		logic [15:0] base;
		base = clr ? 16'h0000 : cur;
		if (!ev)
			bump = base;
		else if (base != maxv)
			bump = base + 16'h0001;
		else if (wrap)
			bump = 16'h0000;
		else
			bump = base;
	endfunction

	function automatic logic ovf(input logic [15:0] cur, input logic [15:0] maxv,
		input logic ev, input logic clr);
		ovf = ev && !clr && (cur == maxv);
	endfunction

	// Place one Sa bit at its odd-frame position, leaving the other positions untouched
	function automatic logic [SA_W-1:0] sa_put(input logic [SA_W-1:0] cur,
		input logic [SA_W-1:0] sel, input logic bit_in, input logic vld);
		sa_put = vld ? ((cur & ~sel) | ({SA_W{bit_in}} & sel)) : cur;
	endfunction

	logic [FRM_W-1:0] frm_ff;
	logic [CRC_W-1:0] crc_ff;
	logic [LCV_W-1:0] lcv_ff;
	logic [FAR_W-1:0] far_ff;
	logic [PAT_W-1:0] pat_ff;
	logic [PAT_W-1:0] pat_vis_ff;
	logic [LOA_W-1:0] loa_ff;
	logic [COA_W-1:0] coa_ff;
	logic [SEF_W-1:0] sef_ff;
	logic [FRM_W-1:0] frm_snap_ff;
	logic [CRC_W-1:0] crc_snap_ff;
	logic [LCV_W-1:0] lcv_snap_ff;
	logic [FAR_W-1:0] far_snap_ff;
	logic [7:0]       alm_snap_ff;
	logic             align_lost_d_ff;
	logic [SA_W-1:0]  sa4_work_ff;
	logic [SA_W-1:0]  sa5_work_ff;
	logic [SA_W-1:0]  sa4_vis_ff;
	logic [SA_W-1:0]  sa5_vis_ff;

	wire        rd_frm_hi = reg_rd && (reg_addr == OFS_FRM_HI);
	wire        rd_crc_hi = reg_rd && (reg_addr == OFS_CRC_HI);
	wire        rd_lcv_hi = reg_rd && (reg_addr == OFS_LCV_HI);
	wire        rd_far    = reg_rd && ((reg_addr == OFS_FAR_LO) || (reg_addr == OFS_FAR_HI));
	wire        rd_pat_lo = reg_rd && (reg_addr == OFS_PAT_LO);
	wire        rd_alm    = reg_rd && (reg_addr == OFS_ALM);
	// Frame, CRC, violation, far-end and alarm reads clear only while the one-second latch is off
	wire        clr_ok    = !one_second_latch_active;
	wire        clr_frm   = rd_frm_hi && clr_ok;
	wire        clr_crc   = rd_crc_hi && clr_ok;
	wire        clr_lcv   = rd_lcv_hi && clr_ok;
	wire        clr_far   = rd_far && clr_ok;
	wire        clr_alm   = rd_alm && clr_ok;
	// Pattern snapshot is a read side effect independent of the latch
	wire        clr_pat   = rd_pat_lo;

	wire        ev_lcv    = bipolar_violation || (excess_zero_in_violation_count
		&& excess_zero_event);
	wire        ev_far    = far_block_error && e1_mode;
	wire        ev_pat    = pattern_bit_error && pattern_test_start;
	wire        ev_loa    = frame_align_lost && !align_lost_d_ff;
	wire [7:0]  wrap      = counter_overflow_irq_enable;

	wire [15:0] frm16 = {4'h0, frm_ff};
	wire [15:0] crc16 = {6'h00, crc_ff};
	wire [15:0] far16 = {6'h00, far_ff};
	wire [15:0] pat16 = {4'h0, pat_ff};
	wire [15:0] loa16 = {12'h000, loa_ff};
	wire [15:0] coa16 = {14'h0000, coa_ff};
	wire [15:0] sef16 = {14'h0000, sef_ff};

	wire [15:0] nxt_frm = bump(frm16, 16'h0fff, framing_bit_error, clr_frm, wrap[OV_FRM]);
	wire [15:0] nxt_crc = bump(crc16, 16'h03ff, crc_error, clr_crc, wrap[OV_CRC]);
	wire [15:0] nxt_lcv = bump(lcv_ff, 16'hffff, ev_lcv, clr_lcv, wrap[OV_LCV]);
	wire [15:0] nxt_far = bump(far16, 16'h03ff, ev_far, clr_far, wrap[OV_FAR]);
	wire [15:0] nxt_pat = bump(pat16, 16'h0fff, ev_pat, clr_pat, wrap[OV_PAT]);
	wire [15:0] nxt_loa = bump(loa16, 16'h000f, ev_loa, clr_alm, wrap[OV_LOA]);
	wire [15:0] nxt_coa = bump(coa16, 16'h0003, alignment_change, clr_alm,
		wrap[OV_COA]);
	wire [15:0] nxt_sef = bump(sef16, 16'h0003, severe_frame_error, clr_alm,
		wrap[OV_SEF]);

	wire [7:0] nxt_ovf = {
		ovf(sef16, 16'h0003, severe_frame_error, clr_alm),
		ovf(coa16, 16'h0003, alignment_change, clr_alm),
		ovf(loa16, 16'h000f, ev_loa, clr_alm),
		ovf(pat16, 16'h0fff, ev_pat, clr_pat),
		ovf(far16, 16'h03ff, ev_far, clr_far),
		ovf(lcv_ff, 16'hffff, ev_lcv, clr_lcv),
		ovf(crc16, 16'h03ff, crc_error, clr_crc),
		ovf(frm16, 16'h0fff, framing_bit_error, clr_frm)};

	// Sa bit placed at position n for odd frame 2n+1
	wire [SA_W-1:0] sa_sel = SA_W'(1) << sa_odd_frame_index;
	wire [SA_W-1:0] nxt_sa4 = sa_put(sa4_work_ff, sa_sel, sa4_bit, sa_bit_valid);
	wire [SA_W-1:0] nxt_sa5 = sa_put(sa5_work_ff, sa_sel, sa5_bit, sa_bit_valid);

	// Counter views: live or one-second snapshot
	wire [FRM_W-1:0] frm_v = one_second_latch_active ? frm_snap_ff : frm_ff;
	wire [CRC_W-1:0] crc_v = one_second_latch_active ? crc_snap_ff : crc_ff;
	wire [LCV_W-1:0] lcv_v = one_second_latch_active ? lcv_snap_ff : lcv_ff;
	wire [FAR_W-1:0] far_v = one_second_latch_active ? far_snap_ff : far_ff;
	wire [7:0]       alm_v = one_second_latch_active ? alm_snap_ff
		: {loa_ff, coa_ff, sef_ff};
	// Pattern low read returns the count being captured in this very read
	wire [PAT_W-1:0] pat_lo_v = pat_ff;

	logic [7:0] nxt_rdata;
	always_comb begin
		unique case (reg_addr)
			OFS_FRM_LO: nxt_rdata = frm_v[7:0];
			OFS_FRM_HI: nxt_rdata = {4'h0, frm_v[11:8]};
			OFS_CRC_LO: nxt_rdata = crc_v[7:0];
			OFS_CRC_HI: nxt_rdata = {6'h00, crc_v[9:8]};
			OFS_LCV_LO: nxt_rdata = lcv_v[7:0];
			OFS_LCV_HI: nxt_rdata = lcv_v[15:8];
			OFS_FAR_LO: nxt_rdata = far_v[7:0];
			OFS_FAR_HI: nxt_rdata = {6'h00, far_v[9:8]};
			OFS_PAT_LO: nxt_rdata = pat_lo_v[7:0];
			OFS_PAT_HI: nxt_rdata = {4'h0, pat_vis_ff[11:8]};
			OFS_ALM:    nxt_rdata = alm_v;
			OFS_SA4:    nxt_rdata = sa4_vis_ff;
			OFS_SA5:    nxt_rdata = sa5_vis_ff;
			default:    nxt_rdata = RST_BYTE;
		endcase
	end

	// One register per counter keeps each read clear local to its own count
	always_ff @(posedge core_clk) begin
		if (!resetn)
			frm_ff <= '0;
		else
			frm_ff <= nxt_frm[FRM_W-1:0];
	end

	always_ff @(posedge core_clk) begin
		if (!resetn)
			crc_ff <= '0;
		else
			crc_ff <= nxt_crc[CRC_W-1:0];
	end

	always_ff @(posedge core_clk) begin
		if (!resetn)
			lcv_ff <= '0;
		else
			lcv_ff <= nxt_lcv;
	end

	always_ff @(posedge core_clk) begin
		if (!resetn)
			far_ff <= '0;
		else
			far_ff <= nxt_far[FAR_W-1:0];
	end

	// Internal pattern count; the visible copy only moves on a low-byte read
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			pat_ff <= '0;
			pat_vis_ff <= '0;
		end else begin
			pat_ff <= nxt_pat[PAT_W-1:0];
			if (rd_pat_lo)
				pat_vis_ff <= pat_ff;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			loa_ff <= '0;
			coa_ff <= '0;
			sef_ff <= '0;
			align_lost_d_ff <= 1'b0;
		end else begin
			loa_ff <= nxt_loa[LOA_W-1:0];
			coa_ff <= nxt_coa[COA_W-1:0];
			sef_ff <= nxt_sef[SEF_W-1:0];
			align_lost_d_ff <= frame_align_lost;
		end
	end

	// Overflow pulse feeds the interrupt, one cycle after an event at the counter maximum
	always_ff @(posedge core_clk) begin
		if (!resetn)
			counter_overflow <= '0;
		else
			counter_overflow <= nxt_ovf;
	end

	// Snapshot taken on the tick; reads served from it never clear the live counts
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			frm_snap_ff <= '0;
			crc_snap_ff <= '0;
			lcv_snap_ff <= '0;
			far_snap_ff <= '0;
			alm_snap_ff <= '0;
		end else if (one_second_tick) begin
			frm_snap_ff <= frm_ff;
			crc_snap_ff <= crc_ff;
			lcv_snap_ff <= lcv_ff;
			far_snap_ff <= far_ff;
			alm_snap_ff <= {loa_ff, coa_ff, sef_ff};
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			sa4_work_ff <= '0;
			sa5_work_ff <= '0;
		end else begin
			sa4_work_ff <= nxt_sa4;
			sa5_work_ff <= nxt_sa5;
		end
	end

	// Both buffers swap together so software sees one consistent multiframe
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			sa4_vis_ff <= '0;
			sa5_vis_ff <= '0;
		end else if (rx_multiframe_irq) begin
			sa4_vis_ff <= nxt_sa4;
			sa5_vis_ff <= nxt_sa5;
		end
	end

	// Registered read data costs one cycle but keeps the address off any output path
	always_ff @(posedge core_clk) begin
		if (!resetn)
			reg_rdata <= RST_BYTE;
		else
			reg_rdata <= nxt_rdata;
	end
endmodule
`default_nettype wire

// *** sim/pmc_counters_assertions.sv ***
// Port-level checks of the monitoring counter bank
`timescale 1ns/100ps
`default_nettype none
module pmc_counters_assertions (
	// Clock and reset
	input wire logic       core_clk,
	input wire logic       resetn,
	// Register port
	input wire logic [8:0] reg_addr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	// Controls and events
	input wire logic       one_second_latch_active,
	input wire logic       framing_bit_error,
	input wire logic       frame_align_lost,
	input wire logic       alignment_change,
	input wire logic       severe_frame_error,
	input wire logic       rx_multiframe_irq,
	input wire logic [7:0] counter_overflow
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	sequence s_quiet;
		!alignment_change && !severe_frame_error && !frame_align_lost;
	endsequence
	property p_frm_hi; reg_addr == 9'h051 |=> reg_rdata[7:4] == 4'h0; endproperty
	a_frm_hi: assert property (p_frm_hi) else $error("framing high byte upper bits set");
	property p_crc_hi; reg_addr == 9'h053 |=> reg_rdata[7:2] == 6'h00; endproperty
	a_crc_hi: assert property (p_crc_hi) else $error("crc high byte upper bits set");
	property p_far_hi; reg_addr == 9'h057 |=> reg_rdata[7:2] == 6'h00; endproperty
	a_far_hi: assert property (p_far_hi) else $error("far block high byte upper bits set");
	property p_pat_hi; reg_addr == 9'h059 |=> reg_rdata[7:4] == 4'h0; endproperty
	a_pat_hi: assert property (p_pat_hi) else $error("pattern high byte upper bits set");
	property p_frm_clr;
		(reg_rd && reg_addr == 9'h051 && !one_second_latch_active && !framing_bit_error)
		##1 !framing_bit_error ##1 (reg_addr == 9'h050 && !one_second_latch_active)
		|=> reg_rdata == 8'h00;
	endproperty
	a_frm_clr: assert property (p_frm_clr) else $error("framing count not cleared");
	property p_alm_clr;
		(reg_rd && reg_addr == 9'h05a && !one_second_latch_active) ##0 s_quiet ##1 s_quiet
		##1 (reg_addr == 9'h05a && !one_second_latch_active) |=> reg_rdata == 8'h00;
	endproperty
	a_alm_clr: assert property (p_alm_clr) else $error("alarm counts not cleared");
	property p_sa_stable;
		(reg_addr == 9'h05b && !rx_multiframe_irq)[*2] |=> $stable(reg_rdata);
	endproperty
	a_sa_stable: assert property (p_sa_stable) else $error("sa buffer changed without pulse");
	property p_ovf_frm; counter_overflow[0] |-> $past(framing_bit_error); endproperty
	a_ovf_frm: assert property (p_ovf_frm) else $error("framing overflow without event");
	property p_ovf_loa;
		counter_overflow[5] |-> $past(frame_align_lost) && !$past(frame_align_lost, 2);
	endproperty
	a_ovf_loa: assert property (p_ovf_loa) else $error("loss overflow without rise");
endmodule
bind pmc_counters pmc_counters_assertions pmc_counters_assertions_i (.core_clk, .resetn,
	.reg_addr, .reg_rd, .reg_rdata, .one_second_latch_active, .framing_bit_error,
	.frame_align_lost, .alignment_change, .severe_frame_error, .rx_multiframe_irq,
	.counter_overflow);
`default_nettype wire

// *** sim/pmc_sa_source.sv ***
// Receive framer model delivering odd-frame Sa4/Sa5 bits and the multiframe pulse
`timescale 1ns/100ps
`default_nettype none
module pmc_sa_source (
	// Clock and bench control
	input  wire logic       core_clk,
	input  wire logic       start,
	input  wire logic [7:0] sa4_byte,
	input  wire logic [7:0] sa5_byte,
	// Toward the counter bank, plus done back to the bench
	output logic            sa_bit_valid,
	output logic [2:0]      sa_odd_frame_index,
	output logic            sa4_bit,
	output logic            sa5_bit,
	output logic            rx_multiframe_irq,
	output logic            done
);
	logic [3:0] step_ff = 4'h0;
	logic       busy_ff = 1'b0;
	always @(posedge core_clk) begin
		if (start && !busy_ff)
			busy_ff <= 1'b1;
		if (busy_ff && step_ff == 4'h8)
			busy_ff <= 1'b0;
		step_ff <= busy_ff ? step_ff + 4'h1 : 4'h0;
	end
	// Bit n carries odd frame 2n+1; off-slot bits are inverted so stale data shows
	assign sa_bit_valid       = busy_ff && !step_ff[3];
	assign sa_odd_frame_index = step_ff[2:0];
	assign sa4_bit            = sa_bit_valid ~^ sa4_byte[step_ff[2:0]];
	assign sa5_bit            = sa_bit_valid ~^ sa5_byte[step_ff[2:0]];
	assign rx_multiframe_irq  = busy_ff && step_ff[3];
	assign done               = !busy_ff;
endmodule
`default_nettype wire

// *** sim/pmc_counters_bench.sv ***
// Self-checking bench for the monitoring counter bank
`timescale 1ns/100ps
`default_nettype none
module pmc_counters_bench;
	import pmc_pkg::*;
	logic       core_clk = 1'b0;
	logic       resetn = 1'b0;
	logic [8:0] reg_addr = 9'h000;
	logic       reg_rd = 1'b0;
	logic [7:0] ov_en = 8'h00;
	logic       latch = 1'b0;
	logic       tick = 1'b0;
	logic       exz = 1'b0;
	logic       pat = 1'b0;
	logic       e1 = 1'b0;
	logic [8:0] ev = 9'h000;
	logic       go = 1'b0;
	logic [7:0] reg_rdata, ovf;
	logic       vld, s4, s5, mf, done;
	logic [2:0] idx;
	int         mismatches = 0;
	int         num_checks = 0;
	always #5 core_clk = ~core_clk;
	// Sticky record of every overflow pulse since reset
	logic [7:0] ovf_seen = 8'h00;
	always @(posedge core_clk) begin
		if (resetn)
			ovf_seen <= ovf_seen | ovf;
	end
	pmc_counters pmc_counters_i (.core_clk, .resetn, .reg_addr, .reg_rd, .reg_rdata,
		.counter_overflow_irq_enable(ov_en), .one_second_latch_active(latch),
		.one_second_tick(tick), .excess_zero_in_violation_count(exz), .pattern_test_start(pat),
		.e1_mode(e1), .framing_bit_error(ev[0]), .crc_error(ev[1]), .bipolar_violation(ev[2]),
		.excess_zero_event(ev[3]), .far_block_error(ev[4]), .pattern_bit_error(ev[5]),
		.frame_align_lost(ev[6]), .alignment_change(ev[7]), .severe_frame_error(ev[8]),
		.sa_bit_valid(vld), .sa_odd_frame_index(idx), .sa4_bit(s4), .sa5_bit(s5),
		.rx_multiframe_irq(mf), .counter_overflow(ovf));
	pmc_sa_source pmc_sa_source_i (.core_clk, .start(go), .sa4_byte(8'ha5), .sa5_byte(8'h3c),
		.sa_bit_valid(vld), .sa_odd_frame_index(idx), .sa4_bit(s4), .sa5_bit(s5),
		.rx_multiframe_irq(mf), .done);
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [8:0] a, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch reg %h expected %h seen %h", a, exp, got);
		end
	endtask
	task automatic chk_ovf(input logic [7:0] exp);
		num_checks++;
		if (ovf_seen !== exp) begin
			mismatches++;
			$display("mismatch overflow expected %h seen %h", exp, ovf_seen);
		end
	endtask
	// One read: strobe for one cycle, data is registered and checked a cycle later
	task automatic rd(input logic [8:0] a, input logic [7:0] exp);
		@(posedge core_clk) #1;
		reg_rd = 1'b1;
		reg_addr = a;
		@(posedge core_clk) #1;
		reg_rd = 1'b0;
		chk(a, exp, reg_rdata);
	endtask
	// Event line k held high for n edges, one count per edge; line 6 (frame_align_lost) counts once per rise
	task automatic pulse(input int k, input int n);
		@(posedge core_clk) #1;
		ev[k] = 1'b1;
		repeat (n) @(posedge core_clk);
		#1;
		ev[k] = 1'b0;
	endtask
	initial begin
		repeat (5) @(posedge core_clk);
		#1;
		resetn = 1'b1;
		for (int a = 'h50; a <= 'h5d; a++) rd(9'(a), 8'h00);
		pulse(0, 'h123);
		rd(OFS_FRM_LO, 8'h23);
		rd(OFS_FRM_HI, 8'h01);
		rd(OFS_FRM_LO, 8'h00);
		pulse(0, 4098);
		rd(OFS_FRM_LO, 8'hff);
		rd(OFS_FRM_HI, 8'h0f);
		ov_en = 8'h21;
		pulse(0, 4097);
		rd(OFS_FRM_LO, 8'h01);
		fork
			rd(OFS_FRM_HI, 8'h00);
			pulse(0, 1);
		join
		rd(OFS_FRM_LO, 8'h01);
		pulse(1, 'h203);
		rd(OFS_CRC_LO, 8'h03);
		rd(OFS_CRC_HI, 8'h02);
		rd(OFS_CRC_LO, 8'h00);
		exz = 1'b1;
		pulse(2, 'h102);
		pulse(3, 2);
		exz = 1'b0;
		pulse(3, 5);
		rd(OFS_LCV_LO, 8'h04);
		rd(OFS_LCV_HI, 8'h01);
		rd(OFS_LCV_LO, 8'h00);
		pulse(4, 3);
		e1 = 1'b1;
		pulse(4, 5);
		rd(OFS_FAR_LO, 8'h05);
		rd(OFS_FAR_HI, 8'h00);
		pulse(4, 'h100);
		rd(OFS_FAR_HI, 8'h01);
		rd(OFS_FAR_LO, 8'h00);
		pulse(5, 3);
		pat = 1'b1;
		pulse(5, 'h105);
		rd(OFS_PAT_LO, 8'h05);
		pulse(5, 2);
		rd(OFS_PAT_HI, 8'h01);
		rd(OFS_PAT_LO, 8'h02);
		rd(OFS_PAT_HI, 8'h00);
		repeat (17) pulse(6, 2);
		pulse(7, 1);
		pulse(8, 5);
		rd(OFS_ALM, 8'h17);
		rd(OFS_ALM, 8'h00);
		chk_ovf(8'ha1);
		latch = 1'b1;
		pulse(1, 2);
		tick = 1'b1;
		@(posedge core_clk) #1;
		tick = 1'b0;
		pulse(1, 1);
		rd(OFS_CRC_LO, 8'h02);
		rd(OFS_CRC_HI, 8'h00);
		rd(OFS_CRC_LO, 8'h02);
		latch = 1'b0;
		rd(OFS_CRC_LO, 8'h03);
		rd(OFS_CRC_HI, 8'h00);
		rd(OFS_CRC_LO, 8'h00);
		go = 1'b1;
		@(posedge core_clk) #1;
		go = 1'b0;
		rd(OFS_SA4, 8'h00);
		for (int i = 0; i < 20 && done !== 1'b1; i++) @(posedge core_clk) #1;
		if (done === 1'b1) begin
			rd(OFS_SA4, 8'ha5);
			rd(OFS_SA5, 8'h3c);
		end else
			mismatches++;
		stop_test();
	end
endmodule
`default_nettype wire
